// ### rtl/thermistor_monitor_cfg.svh
// register map, reset values, field positions and timing constants of the thermistor monitor
// Overview of operation
// - In battery-only operation the thermistor input is sampled once a second when the interval bit is 1, otherwise only on a fault read trigger.
// - Writing 1 to the fault read trigger starts a fault read and the hardware returns the bit to 0 when that read completes.
// - Bit 2 of the fault measurement control register enables fault measurement and resets to 0.
// - In the warm region the regulation target drops by the 3-bit code times 50 mV, code 000 meaning none, reset code 011.
// - When temperature reduces charging the fast-charge current is scaled by (8 minus code)/8, code 000 meaning none, reset code 100.
// - The cold threshold is an 8-bit binary-weighted value of 4.688 mV per step resetting to 0x7c.
// - The cool threshold uses the same weighting as the cold threshold and resets to 0x6d.
// - The thermistor read control register resets to 0x2 with bit 6 reserved and read-only, and the charge reduction register resets to 0x34.
`ifndef THERMISTOR_MONITOR_CFG_SVH
`define THERMISTOR_MONITOR_CFG_SVH

`define ADDR_READ_CTRL      8'h40
`define ADDR_FAULT_MEAS     8'h58
`define ADDR_CHG_REDUCTION  8'h61
`define ADDR_COLD_LIMIT     8'h62
`define ADDR_COOL_LIMIT     8'h63

`define RST_READ_CTRL       8'h02
`define RST_FAULT_MEAS      8'h00
`define RST_CHG_REDUCTION   8'h34
`define RST_COLD_LIMIT      8'h7c
`define RST_COOL_LIMIT      8'h6d

`define BIT_INTERVAL        7
`define BIT_RD_RESERVED     6
`define BIT_TRIGGER         5
`define BIT_MEAS_ENABLE     2
`define VRED_MSB            6
`define VRED_LSB            4
`define ISCALE_MSB          2
`define ISCALE_LSB          0

`define READ_CTRL_WMASK     8'hbf
`define FULL_SCALE_EIGHTHS  4'h8
`define NO_REDUCTION_CODE   3'h0

`define CLK_HZ              20000000
`define SAMPLE_PERIOD_MS    1000
`define MS_PER_S            1000

`endif

// ### rtl/thermistor_monitor_pkg.sv
// types shared by the thermistor monitor modules
package thermistor_monitor_pkg;

  typedef enum logic [1:0] {
    REGION_NORMAL,
    REGION_COOL,
    REGION_COLD,
    REGION_WARM
  } temp_region_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    temp_region_t region;
    logic [2:0]   vbat_steps;
    logic [3:0]   current_eighths;
    logic         charge_hold;
  } charge_adjust_t;

endpackage : thermistor_monitor_pkg

// ### rtl/thermistor_region_eval.sv
// region selection and charge reduction for one thermistor sample
`timescale 1ns/1ps
`default_nettype none
`include "thermistor_monitor_cfg.svh"

module thermistor_region_eval
  import thermistor_monitor_pkg::*;
(
  input  wire logic [7:0]     sample,
  input  wire logic [7:0]     cold_threshold,
  input  wire logic [7:0]     cool_threshold,
  input  wire logic [7:0]     warm_level,
  input  wire logic [2:0]     warm_voltage_reduction,
  input  wire logic [2:0]     temp_current_scale,
  output charge_adjust_t      adjust
);

  // higher voltage on the ntc divider means colder
  wire logic is_cold = sample >= cold_threshold;
  wire logic is_cool = !is_cold && (sample >= cool_threshold);
  wire logic is_warm = !is_cold && !is_cool && (sample < warm_level);

  wire logic [3:0] scaled_eighths = (temp_current_scale == `NO_REDUCTION_CODE) ?
                                    `FULL_SCALE_EIGHTHS :
                                    4'(`FULL_SCALE_EIGHTHS - {1'b0, temp_current_scale});

  wire temp_region_t region = is_cold ? REGION_COLD :
                              is_cool ? REGION_COOL :
                              is_warm ? REGION_WARM : REGION_NORMAL;

  assign adjust.region          = region;
  assign adjust.vbat_steps      = is_warm ? warm_voltage_reduction : `NO_REDUCTION_CODE;
  assign adjust.current_eighths = (is_cool || is_warm) ? scaled_eighths : `FULL_SCALE_EIGHTHS;
  assign adjust.charge_hold     = is_cold;

endmodule : thermistor_region_eval
`default_nettype wire

// ### rtl/thermistor_monitor.sv
// thermistor monitor configuration registers, sampling control and charge adjustment
`timescale 1ns/1ps
`default_nettype none
`include "thermistor_monitor_cfg.svh"

module thermistor_monitor
  import thermistor_monitor_pkg::*;
#(
  parameter int TICK_CYCLES = (`CLK_HZ / `MS_PER_S) * `SAMPLE_PERIOD_MS
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire reg_req_t    reg_req,
  output logic [7:0]       reg_rdata,
  input  wire logic        bat_only,
  output logic             meas_req,
  input  wire logic        meas_done,
  input  wire logic [7:0]  meas_value,
  input  wire logic [7:0]  warm_level,
  output logic             fault_measure_enable,
  output logic             sample_valid,
  output logic [7:0]       last_sample,
  output charge_adjust_t   charge_adjust
);

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  typedef enum logic {
    ST_IDLE,
    ST_MEAS
  } meas_state_t;

  localparam int TICK_W = $clog2(TICK_CYCLES);

  logic [7:0]  read_ctrl;
  logic [7:0]  fault_meas;
  logic [7:0]  chg_reduction;
  logic [7:0]  cold_limit;
  logic [7:0]  cool_limit;
  logic [TICK_W-1:0] tick_count;
  logic        tick;
  logic        tick_pending;
  meas_state_t state;
  meas_state_t next_state;
  charge_adjust_t next_adjust;

  // address decode
  wire logic sel_read_ctrl  = reg_req.addr == `ADDR_READ_CTRL;
  wire logic sel_fault_meas = reg_req.addr == `ADDR_FAULT_MEAS;
  wire logic sel_reduction  = reg_req.addr == `ADDR_CHG_REDUCTION;
  wire logic sel_cold       = reg_req.addr == `ADDR_COLD_LIMIT;
  wire logic sel_cool       = reg_req.addr == `ADDR_COOL_LIMIT;

  wire logic wr_read_ctrl   = reg_req.wr && sel_read_ctrl;

  wire logic [7:0] read_mux = sel_read_ctrl  ? read_ctrl :
                              sel_fault_meas ? fault_meas :
                              sel_reduction  ? chg_reduction :
                              sel_cold       ? cold_limit :
                              sel_cool       ? cool_limit : 8'h00;

  wire logic interval_mode = read_ctrl[`BIT_INTERVAL];
  wire logic trigger       = read_ctrl[`BIT_TRIGGER];

  // periodic sampling in battery-only mode when interval bit is 1; always periodic on adapter power
  wire logic periodic_on   = !bat_only || interval_mode;
  wire logic start_meas    = (state == ST_IDLE) && (trigger || tick_pending);
  wire logic read_complete = (state == ST_MEAS) && meas_done;

  // written 1 wins over the completion clear in the same cycle
  wire logic [7:0] wr_read_val = reg_req.wdata & `READ_CTRL_WMASK;
  wire logic next_trigger = wr_read_ctrl ? wr_read_val[`BIT_TRIGGER] :
                            (read_complete ? 1'b0 : trigger);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_meas) begin
          next_state = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (meas_done) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  thermistor_region_eval u_eval (
    .sample                 (meas_value),
    .cold_threshold         (cold_limit),
    .cool_threshold         (cool_limit),
    .warm_level             (warm_level),
    .warm_voltage_reduction (chg_reduction[`VRED_MSB:`VRED_LSB]),
    .temp_current_scale     (chg_reduction[`ISCALE_MSB:`ISCALE_LSB]),
    .adjust                 (next_adjust)
  );

  // one-second enable divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else begin
      tick       <= tick_count == TICK_W'(TICK_CYCLES - 1);
      tick_count <= (tick_count == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_count + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_pending <= 1'b0;
    end else if (tick && periodic_on) begin
      tick_pending <= 1'b1;
    end else if (start_meas || !periodic_on) begin
      tick_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      read_ctrl <= `RST_READ_CTRL;
    end else begin
      read_ctrl <= wr_read_ctrl ? wr_read_val : read_ctrl;
      read_ctrl[`BIT_TRIGGER]     <= next_trigger;
      read_ctrl[`BIT_RD_RESERVED] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_meas    <= `RST_FAULT_MEAS;
      chg_reduction <= `RST_CHG_REDUCTION;
      cold_limit    <= `RST_COLD_LIMIT;
      cool_limit    <= `RST_COOL_LIMIT;
    end else if (reg_req.wr) begin
      fault_meas    <= sel_fault_meas ? reg_req.wdata : fault_meas;
      chg_reduction <= sel_reduction ? reg_req.wdata : chg_reduction;
      cold_limit    <= sel_cold ? reg_req.wdata : cold_limit;
      cool_limit    <= sel_cool ? reg_req.wdata : cool_limit;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata            <= 8'h00;
      fault_measure_enable <= 1'b0;
    end else begin
      reg_rdata            <= reg_req.rd ? read_mux : reg_rdata;
      fault_measure_enable <= fault_meas[`BIT_MEAS_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      meas_req <= 1'b0;
    end else begin
      state    <= next_state;
      meas_req <= next_state == ST_MEAS;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_valid  <= 1'b0;
      last_sample   <= 8'h00;
      charge_adjust <= '{region: REGION_NORMAL, vbat_steps: `NO_REDUCTION_CODE,
                         current_eighths: `FULL_SCALE_EIGHTHS, charge_hold: 1'b0};
    end else begin
      sample_valid <= read_complete;
      if (read_complete) begin
        last_sample   <= meas_value;
        charge_adjust <= next_adjust;
      end
    end
  end

endmodule : thermistor_monitor
`default_nettype wire

// ### tb/thermistor_monitor_monitor.sv
// port checker for the thermistor monitor
`timescale 1ns/1ps
`default_nettype none
module thermistor_monitor_monitor
  import thermistor_monitor_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst_b,
  input wire reg_req_t       reg_req,
  input wire logic [7:0]     reg_rdata,
  input wire logic           meas_req,
  input wire logic           meas_done,
  input wire logic [7:0]     meas_value,
  input wire logic           fault_measure_enable,
  input wire logic           sample_valid,
  input wire logic [7:0]     last_sample,
  input wire charge_adjust_t charge_adjust
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_fme; reg_req.wr && reg_req.addr == 8'h58 |-> ##2 fault_measure_enable == $past(reg_req.wdata[2], 2); endproperty
  a_fme: assert property (p_fme) else $error("enable copy wrong");
  property p_trig; reg_req.wr && reg_req.addr == 8'h40 && reg_req.wdata[5] && !meas_req |-> ##2 meas_req; endproperty
  a_trig: assert property (p_trig) else $error("trigger did not start a read");
  property p_done; meas_req && meas_done |=> sample_valid && !meas_req && last_sample == $past(meas_value); endproperty
  a_done: assert property (p_done) else $error("completion wrong");
  property p_svld; sample_valid |-> $past(meas_req && meas_done); endproperty
  a_svld: assert property (p_svld) else $error("stray sample pulse");
  property p_hold; charge_adjust.charge_hold == (charge_adjust.region == REGION_COLD); endproperty
  a_hold: assert property (p_hold) else $error("hold not tied to cold");
  property p_vbat; charge_adjust.region != REGION_WARM |-> charge_adjust.vbat_steps == 3'h0; endproperty
  a_vbat: assert property (p_vbat) else $error("voltage drop outside warm");
  property p_cur; charge_adjust.region == REGION_NORMAL |-> charge_adjust.current_eighths == 4'h8; endproperty
  a_cur: assert property (p_cur) else $error("current cut in normal");
  property p_rsv; reg_req.rd && reg_req.addr == 8'h40 |=> !reg_rdata[6]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
endmodule : thermistor_monitor_monitor
bind thermistor_monitor thermistor_monitor_monitor thermistor_monitor_monitor_i (.clk(clk), .rst_b(rst_b),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .meas_req(meas_req), .meas_done(meas_done), .meas_value(meas_value),
  .fault_measure_enable(fault_measure_enable), .sample_valid(sample_valid), .last_sample(last_sample),
  .charge_adjust(charge_adjust));
`default_nettype wire

// ### tb/therm_conv_model.sv
// converter stand-in answering measurement requests
`timescale 1ns/1ps
`default_nettype none
module therm_conv_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       meas_req,
  input  wire logic [7:0] level,
  input  wire logic [3:0] lat,
  output logic            meas_done,
  output logic [7:0]      meas_value
);
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt, meas_done, meas_value} <= '0;
    end else if (meas_req && !meas_done && cnt >= lat) begin
      {cnt, meas_done, meas_value} <= {4'h0, 1'b1, level};
    end else begin
      meas_done <= 1'b0;
      meas_value <= ~meas_value; // not valid outside the pulse
      cnt <= (meas_req && !meas_done) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : therm_conv_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the thermistor monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import thermistor_monitor_pkg::*;
;
  logic           clk, rst_b, bat_only, meas_req, meas_done, fme, sv;
  logic [7:0]     rdata, mval, lsample, level, warm_level, d;
  logic [3:0]     lat;
  reg_req_t       req;
  charge_adjust_t adj;
  int             fails, tests_run, n, k;
  thermistor_monitor #(.TICK_CYCLES(50)) thermistor_monitor_i (.clk(clk), .rst_b(rst_b), .reg_req(req),
    .reg_rdata(rdata), .bat_only(bat_only), .meas_req(meas_req), .meas_done(meas_done), .meas_value(mval),
    .warm_level(warm_level), .fault_measure_enable(fme), .sample_valid(sv), .last_sample(lsample),
    .charge_adjust(adj));
  therm_conv_model therm_conv_model_i (.clk(clk), .rst_b(rst_b), .meas_req(meas_req), .level(level), .lat(lat),
    .meas_done(meas_done), .meas_value(mval));
  task automatic chk(input logic [7:0] e, input logic [7:0] a);
    tests_run++;
    if (e !== a) begin
      fails++;
      $display("[ERR] %0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) req = '{1'b1, 1'b0, a, v};
    @(negedge clk) req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req.rd = 1'b0;
    chk(e, rdata);
  endtask : rd
  task automatic trig(input logic [7:0] v);
    level = v;
    wr(8'h40, 8'h20);
    for (n = 0; n < 40 && sv !== 1'b1; n++) @(negedge clk);
    if (n == 40) begin
      fails++;
      conclude;
    end
    chk(v, lsample);
    rd(8'h40, 8'h00);
  endtask : trig
  task automatic count(input int cycles);
    k = 0;
    repeat (cycles) @(negedge clk) k += int'(sv === 1'b1);
  endtask : count
  task automatic t_reset;
    rd(8'h40, 8'h02);
    rd(8'h58, 8'h00);
    rd(8'h61, 8'h34);
    rd(8'h62, 8'h7c);
    rd(8'h63, 8'h6d);
    rd(8'h10, 8'h00);
  endtask : t_reset
  task automatic t_regs;
    wr(8'h40, 8'hc3);
    rd(8'h40, 8'h83);
    wr(8'h40, 8'h00);
    wr(8'h62, 8'h5a);
    rd(8'h62, 8'h5a);
    wr(8'h63, 8'ha5);
    rd(8'h63, 8'ha5);
    wr(8'h58, 8'h04);
    @(negedge clk);
    chk(8'h01, {7'h0, fme});
    wr(8'h58, 8'h00);
    @(negedge clk);
    chk(8'h00, {7'h0, fme});
    wr(8'h62, 8'h7c);
    wr(8'h63, 8'h6d);
  endtask : t_regs
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      wr(8'h61, {1'b0, c[2:0], 1'b0, c[2:0]});
      trig(8'h10);
      chk({5'h0, c[2:0]}, {5'h0, adj.vbat_steps});
      chk(c == 0 ? 8'h08 : 8'h08 - c[7:0], {4'h0, adj.current_eighths});
    end
  endtask : t_codes
  task automatic t_regions;
    logic [7:0] vs[7] = '{8'h80, 8'h7c, 8'h7b, 8'h6d, 8'h6c, 8'h30, 8'h2f};
    logic [7:0] rg[7] = '{8'h2, 8'h2, 8'h1, 8'h1, 8'h0, 8'h0, 8'h3};
    for (int i = 0; i < 7; i++) begin
      trig(vs[i]);
      chk(rg[i], {6'h0, adj.region});
      chk({7'h0, rg[i] == 8'h2}, {7'h0, adj.charge_hold});
    end
  endtask : t_regions
  task automatic t_interval;
    wr(8'h40, 8'h00);
    repeat (20) @(negedge clk);
    count(200);
    chk(8'h00, k[7:0]);
    lat = 4'h9;
    wr(8'h40, 8'h80);
    count(200);
    chk(8'h01, {7'h0, k >= 3 && k <= 5});
    wr(8'h40, 8'h00);
    bat_only = 1'b0;
    count(200);
    chk(8'h01, {7'h0, k >= 3 && k <= 5});
    bat_only = 1'b1;
  endtask : t_interval
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst_b, fails, tests_run} = '0;
    {req, level, lat} = '0;
    {bat_only, warm_level} = {1'b1, 8'h30};
    lat = 4'h3;
    repeat (8) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    t_reset;
    t_regs;
    t_codes;
    t_regions;
    t_interval;
    conclude;
  end
endmodule : tb_top
`default_nettype wire
